// ---- radio_state_params.svh ----
`ifndef RADIO_STATE_PARAMS_SVH
`define RADIO_STATE_PARAMS_SVH

// Byte addresses of the register words.
`define SMCFG_ADDR 8'h00
`define WAKE_PERIOD_ADDR 8'h04
`define RXTO_CFG_ADDR 8'h08
`define STATUS_ADDR 8'h0c
`define COMMAND_ADDR 8'h10

// State machine configuration word.
`define SMCFG_RESET 8'h30
`define SMCFG_WRITE_MASK 8'h3f
`define CLEAR_SEL_LSB 4
`define RX_NEXT_LSB 2
`define TX_NEXT_LSB 0

// Receive timeout configuration word.
`define RX_TIME_LSB 0
`define RC_OSC_EN_BIT 3
`define WAKE_RES_LSB 4
`define RX_TIME_RESET 3'h7
`define RX_TIME_NONE 3'h7
`define RC_OSC_EN_RESET 1'h0
`define WAKE_RES_RESET 2'h0
`define WAKE_PERIOD_RESET 16'h876a

// Timeout count uses the 13 upper bits of the period at setting 0.
`define TIMEOUT_BASE_SHIFT 4'h3

// Status word.
`define STAT_STATE_LSB 0
`define STAT_CLEAR_BIT 2
`define STAT_TIMEOUT_BIT 3
`define STAT_RECEIVING_BIT 4

// Command word bits.
`define CMD_RX_BIT 0
`define CMD_TX_BIT 1
`define CMD_IDLE_BIT 2
`define CMD_SYNTH_BIT 3

`endif

// ---- radio_state_pkg.sv ----
package radio_state_pkg;

  typedef enum logic [1:0] {
    RADIO_IDLE,
    RADIO_RX,
    RADIO_TX,
    RADIO_SYNTH_TX
  } radio_state_e;

  typedef struct packed {
    logic [1:0] clearChannelSelect;
    logic [1:0] afterReceiveNextState;
    logic [1:0] afterTransmitNextState;
  } sm_config_s;

  typedef struct packed {
    logic [2:0] rxTime;
    logic rcOscEnable;
    logic [1:0] wakeResolution;
  } rx_timeout_config_s;

endpackage

// ---- sync_two_flop.sv ----
`timescale 1ns/1ns

module sync_two_flop #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Data.
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic stage1_ff;
    logic stage2_ff;

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        stage1_ff <= 1'b0;
        stage2_ff <= 1'b0;
      end else if (ce) begin
        stage1_ff <= asyncIn[i];
        stage2_ff <= stage1_ff;
      end
    end

    assign syncOut[i] = stage2_ff;
  end

endmodule

// ---- rx_timeout_counter.sv ----
`timescale 1ns/1ns
`include "radio_state_params.svh"

module rx_timeout_counter (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Control.
  input wire logic restart,
  input wire logic run,
  input wire logic rcTick,
  input wire logic [2:0] rxTime,
  input wire logic [15:0] wakeEventPeriod,
  // Result.
  output logic expired
);

  logic [15:0] limit;
  logic [12:0] count_ff;
  logic done_ff;

  // Setting 0 keeps 13 upper bits, each further step drops one bit.
  assign limit = wakeEventPeriod >> (`TIMEOUT_BASE_SHIFT + {1'b0, rxTime});

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_ff <= 13'h0000;
      done_ff <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        count_ff <= 13'h0000;
        done_ff <= 1'b0;
      end else if (run && rcTick && !done_ff) begin
        if ({3'h0, count_ff} + 16'h0001 >= limit) begin
          done_ff <= 1'b1;
        end
        count_ff <= count_ff + 13'h0001;
      end
    end
  end

  // One pulse per receive period; a zero limit expires on the first tick.
  assign expired = run && rcTick && !done_ff && !restart && ({3'h0, count_ff} + 16'h0001 >= limit);

endmodule

// ---- radio_state_control.sv ----
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "radio_state_params.svh"


module radio_state_control #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Modem pins.
  input wire logic rssiBelowThreshold,
  input wire logic packetReceiving,
  input wire logic rcOscClock,
  // Modem events on the same clock.
  input wire logic rxPacketDone,
  input wire logic txPacketDone,
  // Radio outputs.
  output radio_state_pkg::radio_state_e radioState,
  output logic clearChannel,
  output logic rcOscEnable,
  output radio_state_pkg::rx_timeout_config_s rxTimeoutConfig,
  output logic rxTimeoutPulse
);

  import radio_state_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  sm_config_s smConfig_ff;
  rx_timeout_config_s rxtoConfig_ff;
  logic [15:0] wakePeriod_ff;
  logic timeoutSeen_ff;
  radio_state_e state_ff;
  radio_state_e nxt_state;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic access;
  logic wrStrobe;
  logic [2:0] pinSync;
  logic rssiLow;
  logic receiving;
  logic rcLevel;
  logic rcLevelPrev_ff;
  logic rcTick;
  logic clear_ff;
  logic nxt_clear;
  logic timerRestart;
  logic timerRun;
  logic timerExpired;
  logic cmdWrite;
  logic [7:0] smcfgWord;
  logic [7:0] rxtoWord;
  logic [7:0] statusWord;
  logic [ADDR_W-1:0] wordAddr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and RC oscillator edge detection.

  sync_two_flop #(
    .W(3)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .asyncIn({rcOscClock, packetReceiving, rssiBelowThreshold}),
    .syncOut(pinSync)
  );

  assign rssiLow = pinSync[0];
  assign receiving = pinSync[1];
  assign rcLevel = pinSync[2];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rcLevelPrev_ff <= 1'b0;
    end else if (ce) begin
      rcLevelPrev_ff <= rcLevel;
    end
  end

  // One tick per RC period, only while software keeps the oscillator on.
  assign rcTick = rcLevel && !rcLevelPrev_ff && rxtoConfig_ff.rcOscEnable;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode.

  assign access = cyc_i && stb_i && !ack_ff;
  assign wrStrobe = access && we_i && sel_i[0];
  assign wordAddr = {adr_i[ADDR_W-1:2], 2'b00};
  assign cmdWrite = wrStrobe && (wordAddr == ADDR_W'(`COMMAND_ADDR));

  assign smcfgWord = {2'b00, smConfig_ff};
  assign rxtoWord = {2'b00, rxtoConfig_ff.wakeResolution, rxtoConfig_ff.rcOscEnable, rxtoConfig_ff.rxTime};
  assign statusWord = {3'b000, receiving, timeoutSeen_ff, clear_ff, state_ff};

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (wordAddr)
      ADDR_W'(`SMCFG_ADDR): begin
        nxt_rdata = {24'h00_0000, smcfgWord};
      end
      ADDR_W'(`WAKE_PERIOD_ADDR): begin
        nxt_rdata = {16'h0000, wakePeriod_ff};
      end
      ADDR_W'(`RXTO_CFG_ADDR): begin
        nxt_rdata = {24'h00_0000, rxtoWord};
      end
      ADDR_W'(`STATUS_ADDR): begin
        nxt_rdata = {24'h00_0000, statusWord};
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      ack_ff <= access;
      if (access && !we_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      smConfig_ff <= sm_config_s'(6'(`SMCFG_RESET));
    end else if (ce && wrStrobe && wordAddr == ADDR_W'(`SMCFG_ADDR)) begin
      smConfig_ff <= sm_config_s'(dat_i[5:0] & 6'(`SMCFG_WRITE_MASK));
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wakePeriod_ff <= `WAKE_PERIOD_RESET;
    end else if (ce && access && we_i && wordAddr == ADDR_W'(`WAKE_PERIOD_ADDR)) begin
      if (sel_i[0]) begin
        wakePeriod_ff[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        wakePeriod_ff[15:8] <= dat_i[15:8];
      end
    end
  end

  // Wake resolution is stored for the wake timer; any value is accepted.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxtoConfig_ff.rxTime <= `RX_TIME_RESET;
      rxtoConfig_ff.rcOscEnable <= `RC_OSC_EN_RESET;
      rxtoConfig_ff.wakeResolution <= `WAKE_RES_RESET;
    end else if (ce && wrStrobe && wordAddr == ADDR_W'(`RXTO_CFG_ADDR)) begin
      rxtoConfig_ff.rxTime <= dat_i[`RX_TIME_LSB +: 3];
      rxtoConfig_ff.rcOscEnable <= dat_i[`RC_OSC_EN_BIT];
      rxtoConfig_ff.wakeResolution <= dat_i[`WAKE_RES_LSB +: 2];
    end
  end

  assign rcOscEnable = rxtoConfig_ff.rcOscEnable;
  assign rxTimeoutConfig = rxtoConfig_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Clear channel indication.

  always_comb begin
    nxt_clear = 1'b1;
    case (smConfig_ff.clearChannelSelect)
      2'h0: begin
        nxt_clear = 1'b1;
      end
      2'h1: begin
        nxt_clear = rssiLow;
      end
      2'h2: begin
        nxt_clear = !receiving;
      end
      2'h3: begin
        nxt_clear = rssiLow && !receiving;
      end
      default: begin
        nxt_clear = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clear_ff <= 1'b0;
    end else if (ce) begin
      clear_ff <= nxt_clear;
    end
  end

  assign clearChannel = clear_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Receive timeout.

  // The counter needs the RC ticks, rxTime and the wake period register; wake-on-radio state is not consulted.
  assign timerRun = state_ff == RADIO_RX && rxtoConfig_ff.rxTime != `RX_TIME_NONE && !receiving;
  // Restart never looks at the next state, which itself depends on the expiry.
  assign timerRestart = state_ff != RADIO_RX || rxPacketDone || cmdWrite;

  rx_timeout_counter u_timeout (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .restart(timerRestart),
    .run(timerRun),
    .rcTick(rcTick),
    .rxTime(rxtoConfig_ff.rxTime),
    .wakeEventPeriod(wakePeriod_ff),
    .expired(timerExpired)
  );

  assign rxTimeoutPulse = timerExpired && ce;

  // A new timeout wins over a write-one clear in the same cycle.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timeoutSeen_ff <= 1'b0;
    end else if (ce) begin
      if (timerExpired) begin
        timeoutSeen_ff <= 1'b1;
      end else if (wrStrobe && wordAddr == ADDR_W'(`STATUS_ADDR) && dat_i[`STAT_TIMEOUT_BIT]) begin
        timeoutSeen_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main state machine.

  always_comb begin
    nxt_state = state_ff;
    if (cmdWrite && dat_i[`CMD_IDLE_BIT]) begin
      nxt_state = RADIO_IDLE;
    end else if (cmdWrite && dat_i[`CMD_TX_BIT]) begin
      nxt_state = RADIO_TX;
    end else if (cmdWrite && dat_i[`CMD_RX_BIT]) begin
      nxt_state = RADIO_RX;
    end else if (cmdWrite && dat_i[`CMD_SYNTH_BIT]) begin
      nxt_state = RADIO_SYNTH_TX;
    end else begin
      case (state_ff)
        RADIO_RX: begin
          if (rxPacketDone) begin
            case (smConfig_ff.afterReceiveNextState)
              2'h0: nxt_state = RADIO_IDLE;
              2'h1: nxt_state = RADIO_SYNTH_TX;
              2'h2: nxt_state = RADIO_TX;
              default: nxt_state = RADIO_RX;
            endcase
          end else if (timerExpired) begin
            nxt_state = RADIO_IDLE;
          end
        end
        RADIO_TX: begin
          if (txPacketDone) begin
            case (smConfig_ff.afterTransmitNextState)
              2'h0: nxt_state = RADIO_IDLE;
              2'h1: nxt_state = RADIO_SYNTH_TX;
              2'h2: nxt_state = RADIO_TX;
              default: nxt_state = RADIO_RX;
            endcase
          end
        end
        RADIO_IDLE: begin
          nxt_state = RADIO_IDLE;
        end
        RADIO_SYNTH_TX: begin
          nxt_state = RADIO_SYNTH_TX;
        end
        default: begin
          nxt_state = RADIO_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= RADIO_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign radioState = state_ff;

endmodule

// ---- radio_state_control_sva.sv ----
`timescale 1ns/1ns
`include "radio_state_params.svh"

module radio_state_control_sva #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Bus.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Radio.
  input wire logic rssiBelowThreshold,
  input wire logic packetReceiving,
  input wire logic rxPacketDone,
  input wire logic txPacketDone,
  input wire radio_state_pkg::radio_state_e radioState,
  input wire logic clearChannel,
  input wire logic rcOscEnable,
  input wire radio_state_pkg::rx_timeout_config_s rxTimeoutConfig,
  input wire logic rxTimeoutPulse
);
  import radio_state_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic take, cmdWr, cfgWr;
  logic [5:0] cfg_ff;
  logic [2:0] cfgAge_ff, pinAge_ff;
  logic [1:0] pins_ff;
  assign take = cyc_i && stb_i && !ack_o && ce;
  assign cfgWr = take && we_i && sel_i[0] && adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`SMCFG_ADDR >> 2);
  assign cmdWr = take && we_i && sel_i[0] && adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`COMMAND_ADDR >> 2);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff <= 6'(`SMCFG_RESET);
      cfgAge_ff <= 3'h0;
    end else if (cfgWr) begin
      cfg_ff <= dat_i[5:0];
      cfgAge_ff <= 3'h0;
    end else if (cfgAge_ff != 3'h7) begin
      cfgAge_ff <= cfgAge_ff + 3'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins_ff <= 2'h0;
      pinAge_ff <= 3'h0;
    end else begin
      pins_ff <= {rssiBelowThreshold, packetReceiving};
      if ({rssiBelowThreshold, packetReceiving} != pins_ff || !ce)
        pinAge_ff <= 3'h0;
      else if (pinAge_ff != 3'h7)
        pinAge_ff <= pinAge_ff + 3'h1;
    end
  end
  // Settings 0..3 map to idle, synth-on, transmit, receive, which is minus the setting.
  function automatic radio_state_e nxt(logic [1:0] m);
    return radio_state_e'(2'h0 - m);
  endfunction
  sequence s_cfgRead;
    take && !we_i && adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`SMCFG_ADDR >> 2) ##1 ack_o;
  endsequence
  sequence s_ackPulse;
    ack_o ##1 !ack_o;
  endsequence
  property p_ack; take |=> s_ackPulse; endproperty
  property p_cfgRead; s_cfgRead |-> dat_o[7:0] == {2'h0, $past(cfg_ff)}; endproperty
  property p_clear;
    pinAge_ff == 3'h7 && cfgAge_ff > 3'h3 |->
      clearChannel == ((!cfg_ff[4] || rssiBelowThreshold) && (!cfg_ff[5] || !packetReceiving));
  endproperty
  property p_rxDone;
    radioState == RADIO_RX && rxPacketDone && !cmdWr && !rxTimeoutPulse |=> radioState == nxt(cfg_ff[3:2]);
  endproperty
  property p_txDone; radioState == RADIO_TX && txPacketDone && !cmdWr |=> radioState == nxt(cfg_ff[1:0]); endproperty
  property p_toIdle; rxTimeoutPulse && !cmdWr |=> radioState == RADIO_IDLE; endproperty
  property p_onePulse; rxTimeoutPulse |=> !rxTimeoutPulse [*8]; endproperty
  property p_noRc; (!rcOscEnable) [*4] |-> !rxTimeoutPulse; endproperty
  property p_never; rxTimeoutConfig.rxTime == 3'h7 |-> !rxTimeoutPulse; endproperty
  property p_onlyRx; radioState != RADIO_RX |-> !rxTimeoutPulse; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  a_cfgRead: assert property (p_cfgRead) else $error("config readback wrong");
  a_clear: assert property (p_clear) else $error("clear channel wrong");
  a_rxDone: assert property (p_rxDone) else $error("state after receive wrong");
  a_txDone: assert property (p_txDone) else $error("state after transmit wrong");
  a_toIdle: assert property (p_toIdle) else $error("timeout did not stop receive");
  a_onePulse: assert property (p_onePulse) else $error("timeout pulsed twice");
  a_noRc: assert property (p_noRc) else $error("timeout without oscillator");
  a_never: assert property (p_never) else $error("timeout with setting seven");
  a_onlyRx: assert property (p_onlyRx) else $error("timeout outside receive");
endmodule

// ---- radio_host.sv ----
`timescale 1ns/1ns

module radio_host (
  // Clock.
  input wire logic ref_clk,
  // Wishbone master.
  output logic cyc_i,
  output logic stb_i,
  output logic we_i,
  output logic [7:0] adr_i,
  output logic [3:0] sel_i,
  output logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o
);
  initial begin
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h0;
    sel_i = 4'h0;
    dat_i = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output bit ok);
    @(posedge ref_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    ok = 1'b0;
    q = 32'h0;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge ref_clk);
      if (ack_o === 1'b1) begin
        ok = 1'b1;
        q = dat_o;
      end
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
endmodule

// ---- radio_state_control_config_test.sv ----
`timescale 1ns/1ns
`include "radio_state_params.svh"

module radio_state_control_config_test;
  import radio_state_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic cyc_i, stb_i, we_i, ack_o, clearChannel, rcOscEnable, rxTimeoutPulse;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic rssiBelowThreshold = 1'b0, packetReceiving = 1'b0, rcOscClock = 1'b0;
  logic rxPacketDone = 1'b0, txPacketDone = 1'b0;
  radio_state_e radioState;
  rx_timeout_config_s rxTimeoutConfig;
  int errors = 0, samples_checked = 0;
  logic [31:0] seed = 32'h7fec327d;
  always #10 ref_clk = ~ref_clk;
  radio_state_control dut_u (.*);
  radio_host host_u (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic stop_test();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    bit ok;
    host_u.xfer(w, a, d, q, ok);
    if (!ok) begin
      errors++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic pulse(input logic t);
    @(posedge ref_clk);
    txPacketDone <= t;
    rxPacketDone <= !t;
    @(posedge ref_clk);
    rxPacketDone <= 1'b0;
    txPacketDone <= 1'b0;
    @(negedge ref_clk);
  endtask
  initial begin
    logic [31:0] q;
    logic [1:0] m, cs;
    logic [2:0] t;
    logic [15:0] per;
    int seen;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(1'b0, `SMCFG_ADDR, 32'h0, q);
    chk(q, 32'h30);
    bus(1'b0, `RXTO_CFG_ADDR, 32'h0, q);
    chk(q, 32'h7);
    wr(`SMCFG_ADDR, 32'hff);
    bus(1'b0, `SMCFG_ADDR, 32'h0, q);
    chk(q, 32'h3f);
    bus(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    for (int i = 0; i < 12; i++) begin
      cs = (i < 4) ? 2'(i) : 2'(rnd());
      wr(`SMCFG_ADDR, {26'h0, cs, 4'h0});
      q = rnd();
      @(posedge ref_clk);
      rssiBelowThreshold <= q[0];
      packetReceiving <= q[1];
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(32'(clearChannel), 32'((!cs[0] || q[0]) && (!cs[1] || !q[1])));
    end
    wr(`SMCFG_ADDR, 32'h10);
    @(posedge ref_clk);
    ce <= 1'b0;
    rssiBelowThreshold <= !rssiBelowThreshold;
    packetReceiving <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(32'(clearChannel), 32'(!rssiBelowThreshold));
    @(posedge ref_clk);
    ce <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(32'(clearChannel), 32'(rssiBelowThreshold));
    for (int i = 0; i < 16; i++) begin
      m = (i < 8) ? 2'(i >> 1) : 2'(rnd());
      cs = (!i[0] && (m == 2'h1 || m == 2'h2)) ? 2'h0 : 2'(rnd());
      wr(`SMCFG_ADDR, i[0] ? {26'h0, cs, 2'h0, m} : {26'h0, cs, m, 2'h0});
      wr(`COMMAND_ADDR, 32'h1 << (i[0] ? `CMD_TX_BIT : `CMD_RX_BIT));
      pulse(i[0]);
      chk(32'(radioState), 32'(2'(2'h0 - m)));
      wr(`COMMAND_ADDR, 32'h1 << `CMD_IDLE_BIT);
    end
    for (int j = 0; j < 4; j++) begin
      t = (j == 0) ? 3'h0 : (j == 1) ? 3'h6 : 3'(rnd() % 7);
      per = 16'((rnd() % 8 + 1) << (3 + t));
      q = rnd();
      wr(`WAKE_PERIOD_ADDR, 32'(per));
      wr(`RXTO_CFG_ADDR, {26'h0, 1'b0, q[0], j != 3, t});
      chk(32'(rxTimeoutConfig), 32'({t, j != 3, 1'b0, q[0]}));
      chk(32'(rcOscEnable), 32'(j != 3));
      wr(`COMMAND_ADDR, 32'h1 << `CMD_RX_BIT);
      seen = 0;
      for (int k = 1; k <= 12; k++) begin
        for (int c = 0; c < 16; c++) begin
          @(posedge ref_clk);
          rcOscClock <= (c < 8);
          @(negedge ref_clk);
          if (rxTimeoutPulse === 1'b1)
            seen = k;
        end
      end
      chk(32'(seen), (j == 3) ? 32'h0 : 32'(per >> (3 + t)));
      chk(32'(radioState), (j == 3) ? 32'(RADIO_RX) : 32'(RADIO_IDLE));
      bus(1'b0, `STATUS_ADDR, 32'h0, q);
      chk(32'(q[`STAT_TIMEOUT_BIT]), 32'(j != 3));
      chk(32'(q[`STAT_STATE_LSB +: 2]), (j == 3) ? 32'(RADIO_RX) : 32'(RADIO_IDLE));
      wr(`STATUS_ADDR, 32'h1 << `STAT_TIMEOUT_BIT);
      wr(`COMMAND_ADDR, 32'h1 << `CMD_IDLE_BIT);
    end
    stop_test();
  end
endmodule

bind radio_state_control radio_state_control_sva #(.ADDR_W(ADDR_W)) chk_u (.*);
